// [fci_ahb_slave.sv]
// AHB-Lite slave front end: turns bus transfers into register strokes.
// Assumes single word transfers; reads take one wait state, writes none.
module fci_ahb_slave (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [fci_pkg::DATA_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [fci_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [fci_pkg::DATA_W-1:0]       hrdata,
  fci_reg_if.slave                         reg_bus
);

  typedef struct packed {
    fci_pkg::fci_bus_state_t    state;
    logic                       ph_wr;
    logic [fci_pkg::IDX_W-1:0]  ph_idx;
    logic [fci_pkg::DATA_W-1:0] rdata;
  } fci_bus_t;

  fci_bus_t r;
  fci_bus_t next_r;

  // Address phase capture; the read wait state lets a preceding write land first
  always_comb begin
    next_r = r;
    next_r.ph_wr = 1'b0;
    case (r.state)
      fci_pkg::FCI_BUS_IDLE: begin
        if (hsel && htrans[fci_pkg::HTRANS_ACTIVE_BIT] && hready) begin
          next_r.ph_idx = haddr[fci_pkg::ADDR_IDX_MSB:fci_pkg::ADDR_IDX_LSB];
          if (hwrite) begin
            next_r.ph_wr = 1'b1;
          end else begin
            next_r.state = fci_pkg::FCI_BUS_RDWAIT;
          end
        end
      end
      fci_pkg::FCI_BUS_RDWAIT: begin
        next_r.rdata = reg_bus.rdata;
        next_r.state = fci_pkg::FCI_BUS_IDLE;
      end
      default: begin
        next_r.state = fci_pkg::FCI_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{state: fci_pkg::FCI_BUS_IDLE, ph_wr: 1'b0, ph_idx: '0, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  // Write data is taken straight from the bus in its data phase
  assign reg_bus.wr_stb = r.ph_wr;
  assign reg_bus.idx    = r.ph_idx;
  assign reg_bus.wdata  = hwdata;
  assign hreadyout      = (r.state != fci_pkg::FCI_BUS_RDWAIT);
  assign hrdata         = r.rdata;

endmodule : fci_ahb_slave

// [fci_flash_cmd_if.sv]
// Flash command interface: register file, command launch and result capture.
// Assumes a memory controller that starts on cmd_start and pulses ctrl_done.
// Register words by index; the byte address is four times the index
//   0x00 flash_clock_divider, bits 6..0
//   0x02 command_object_index, select in bits 2..0
//   0x03 ecc_result_index, select in bits 2..0
//   0x04 interrupt enables: bit 7 completion, bit 0 error
//   0x06 flash_status_reg: bit 7 done, bit 5 access, bit 4 protection
//   0x07 ECC fault flags: bit 1 double, bit 0 single
//   0x0a command_object_array word at the command index
//   0x0e ecc_error_results word at the ECC index
//   0x12 factory_reserved_a and 0x13 factory_reserved_b read zero
//   All other words read zero and ignore writes
module fci_flash_cmd_if #(
  parameter int unsigned WORD_W = fci_pkg::WORD_W,
  parameter int unsigned DIV_W  = fci_pkg::DIV_W
) (
  // Clock, reset and register bus
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [fci_pkg::DATA_W-1:0]           haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [fci_pkg::DATA_W-1:0]           hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [fci_pkg::DATA_W-1:0]                hrdata,
  // Command handoff to the memory controller
  output logic                                      cmd_start,
  output logic                                      cmd_busy,
  output logic [fci_pkg::WORDS*WORD_W-1:0]          cmd_words,
  // Results and fault reports from the controller
  input  wire logic                                 ctrl_done,
  input  wire logic                                 res_we,
  input  wire logic [fci_pkg::SEL_W-1:0]            res_sel,
  input  wire logic [WORD_W-1:0]                    res_data,
  input  wire logic                                 access_error_set,
  input  wire logic                                 protection_violation_set,
  input  wire logic                                 ecc_single_set,
  input  wire logic                                 ecc_double_set,
  input  wire logic                                 ecc_we,
  input  wire logic [fci_pkg::SEL_W-1:0]            ecc_sel,
  input  wire logic [WORD_W-1:0]                    ecc_data,
  // Time base and interrupt requests
  output logic                                      flash_time_tick,
  output logic                                      cmd_complete_irq,
  output logic                                      flash_error_irq
);

  localparam int unsigned WORDS = fci_pkg::WORDS;
  localparam int unsigned SEL_W = fci_pkg::SEL_W;
  localparam int unsigned DW    = fci_pkg::DATA_W;

  typedef struct packed {
    fci_pkg::fci_cmd_state_t          state;
    logic [DIV_W-1:0]                 flash_clock_divider;
    logic [SEL_W-1:0]                 cmd_word_select;
    logic [SEL_W-1:0]                 ecc_word_select;
    logic                             cmd_ie;
    logic                             err_ie;
    logic                             access_error_flag;
    logic                             protection_violation_flag;
    logic                             ecc_single_flag;
    logic                             ecc_double_flag;
    logic                             start;
    logic [WORDS-1:0][WORD_W-1:0]     command_object_array;
    logic [WORDS-1:0][WORD_W-1:0]     ecc_error_results;
  } fci_regs_t;

  fci_regs_t r;
  fci_regs_t next_r;

  // Register strokes from the bus front end
  fci_reg_if reg_bus ();

  logic cmd_complete_flag;
  logic wr_clkdiv;
  logic wr_cmd_word_select;
  logic wr_ecc_word_select;
  logic wr_config;
  logic wr_status;
  logic wr_errstat;
  logic wr_ccob;
  logic launch_ok;
  logic acc_clkdiv;
  logic acc_config;
  logic acc_ccob;
  logic clr_access;
  logic clr_protect;
  logic clr_single;
  logic clr_double;

  logic [WORD_W-1:0] cmd_word_rd;
  logic [WORD_W-1:0] ecc_word_rd;

  // Bus front end
  fci_ahb_slave fci_ahb_slave_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .reg_bus   (reg_bus)
  );

  // Program and erase timing runs only while a command executes
  fci_time_base #(
    .DIV_W (DIV_W)
  ) fci_time_base_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .divider (r.flash_clock_divider),
    .run     (r.state == fci_pkg::FCI_CMD_BUSY),
    .tick    (flash_time_tick)
  );

  assign cmd_complete_flag = (r.state == fci_pkg::FCI_CMD_READY);

  // Write decode; size is ignored since only whole word transfers occur
  assign wr_clkdiv  = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_CLKDIV);
  assign wr_cmd_word_select  = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_CMD_WORD_SELECT);
  assign wr_ecc_word_select  = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_ECC_WORD_SELECT);
  assign wr_config  = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_CONFIG);
  assign wr_status  = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_STATUS);
  assign wr_errstat = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_ERRSTAT);
  assign wr_ccob    = reg_bus.wr_stb && (reg_bus.idx == fci_pkg::IDX_CCOB);

  // A launch needs an idle engine, a written one and both error flags clear
  assign launch_ok = wr_status && reg_bus.wdata[fci_pkg::STAT_CMD_COMPLETE_FLAG_BIT] && cmd_complete_flag
                     && !r.access_error_flag && !r.protection_violation_flag;

  // Divider, enables and parameter words only land between commands
  assign acc_clkdiv = wr_clkdiv && cmd_complete_flag;
  assign acc_config = wr_config && cmd_complete_flag;
  assign acc_ccob   = wr_ccob && cmd_complete_flag;

  // Write-one-to-clear strobes, one for each error flag
  assign clr_access  = wr_status && reg_bus.wdata[fci_pkg::STAT_ACCESS_ERROR_FLAG_BIT];
  assign clr_protect = wr_status && reg_bus.wdata[fci_pkg::STAT_PROTECTION_VIOLATION_FLAG_BIT];
  assign clr_single  = wr_errstat && reg_bus.wdata[fci_pkg::ERR_SINGLE_BIT];
  assign clr_double  = wr_errstat && reg_bus.wdata[fci_pkg::ERR_DOUBLE_BIT];

  // Array words addressed by the two index registers
  assign cmd_word_rd = r.command_object_array[r.cmd_word_select];
  assign ecc_word_rd = r.ecc_error_results[r.ecc_word_select];

  // Next state of the whole register file
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;

    // Divider and interrupt enables are frozen while a command runs
    if (acc_clkdiv) begin
      next_r.flash_clock_divider = reg_bus.wdata[DIV_W-1:0];
    end
    if (acc_config) begin
      next_r.cmd_ie = reg_bus.wdata[fci_pkg::CFG_CCIE_BIT];
      next_r.err_ie = reg_bus.wdata[fci_pkg::CFG_ERRIE_BIT];
    end

    // Index registers keep only their low select bits
    if (wr_cmd_word_select) begin
      next_r.cmd_word_select = reg_bus.wdata[SEL_W-1:0];
    end
    if (wr_ecc_word_select) begin
      next_r.ecc_word_select = reg_bus.wdata[SEL_W-1:0];
    end

    // Parameter words only enter while no command holds the array
    if (acc_ccob) begin
      next_r.command_object_array[r.cmd_word_select] = reg_bus.wdata[WORD_W-1:0];
    end

    // Error flags: software clears by writing one, hardware set wins
    if (clr_access) begin
      next_r.access_error_flag = 1'b0;
    end
    if (clr_protect) begin
      next_r.protection_violation_flag = 1'b0;
    end
    if (clr_single) begin
      next_r.ecc_single_flag = 1'b0;
    end
    if (clr_double) begin
      next_r.ecc_double_flag = 1'b0;
    end

    // Set pulses come after the clears, so a set wins
    if (access_error_set) begin
      next_r.access_error_flag = 1'b1;
    end
    if (protection_violation_set) begin
      next_r.protection_violation_flag = 1'b1;
    end
    if (ecc_single_set) begin
      next_r.ecc_single_flag = 1'b1;
    end
    if (ecc_double_set) begin
      next_r.ecc_double_flag = 1'b1;
    end

    // Fault results are written by the controller whenever it finds one
    if (ecc_we) begin
      next_r.ecc_error_results[ecc_sel] = ecc_data;
    end

    // Command engine
    case (r.state)
      fci_pkg::FCI_CMD_READY: begin
        // A refused launch changes nothing and sets no flag
        if (launch_ok) begin
          next_r.state = fci_pkg::FCI_CMD_BUSY;
          next_r.start = 1'b1;
        end
      end
      fci_pkg::FCI_CMD_BUSY: begin
        // The array carries the results back to software
        if (res_we) begin
          next_r.command_object_array[res_sel] = res_data;
        end
        // A done pulse outside a command is ignored
        if (ctrl_done) begin
          next_r.state = fci_pkg::FCI_CMD_READY;
        end
      end
      default: begin
        next_r.state = fci_pkg::FCI_CMD_READY;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Engine idle, selects at zero, flags clear, arrays zeroed
      r.state                     <= fci_pkg::FCI_CMD_READY;
      r.flash_clock_divider       <= fci_pkg::CLKDIV_RST;
      r.cmd_word_select           <= fci_pkg::SEL_RST;
      r.ecc_word_select           <= fci_pkg::SEL_RST;
      r.cmd_ie                    <= 1'b0;
      r.err_ie                    <= 1'b0;
      r.access_error_flag         <= 1'b0;
      r.protection_violation_flag <= 1'b0;
      r.ecc_single_flag           <= 1'b0;
      r.ecc_double_flag           <= 1'b0;
      r.start                     <= 1'b0;
      r.command_object_array      <= '{default: fci_pkg::WORD_RST};
      r.ecc_error_results         <= '{default: fci_pkg::WORD_RST};
    end else begin
      r <= next_r;
    end
  end

  // Read multiplexer; unmapped and reserved words read zero
  always_comb begin
    logic [DW-1:0] rd;
    rd = '0;
    case (reg_bus.idx)
      fci_pkg::IDX_CLKDIV: begin
        rd = DW'(r.flash_clock_divider);
      end
      fci_pkg::IDX_CMD_WORD_SELECT: begin
        // Bits above the select field read zero
        rd = DW'(r.cmd_word_select);
      end
      fci_pkg::IDX_ECC_WORD_SELECT: begin
        rd = DW'(r.ecc_word_select);
      end
      fci_pkg::IDX_CONFIG: begin
        rd[fci_pkg::CFG_CCIE_BIT]  = r.cmd_ie;
        rd[fci_pkg::CFG_ERRIE_BIT] = r.err_ie;
      end
      fci_pkg::IDX_STATUS: begin
        // The completion flag is the idle state of the engine
        rd[fci_pkg::STAT_CMD_COMPLETE_FLAG_BIT]   = cmd_complete_flag;
        rd[fci_pkg::STAT_ACCESS_ERROR_FLAG_BIT] = r.access_error_flag;
        rd[fci_pkg::STAT_PROTECTION_VIOLATION_FLAG_BIT] = r.protection_violation_flag;
      end
      fci_pkg::IDX_ERRSTAT: begin
        rd[fci_pkg::ERR_SINGLE_BIT] = r.ecc_single_flag;
        rd[fci_pkg::ERR_DOUBLE_BIT] = r.ecc_double_flag;
      end
      fci_pkg::IDX_CCOB: begin
        rd = DW'(cmd_word_rd);
      end
      fci_pkg::IDX_ECCR: begin
        rd = DW'(ecc_word_rd);
      end
      fci_pkg::IDX_RSV_A: begin
        rd = fci_pkg::RSV_READ;
      end
      fci_pkg::IDX_RSV_B: begin
        rd = fci_pkg::RSV_READ;
      end
      default: begin
        rd = '0;
      end
    endcase
    reg_bus.rdata = rd;
  end

  // Parameter words handed to the memory controller
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_words
      assign cmd_words[gi*WORD_W +: WORD_W] = r.command_object_array[gi];
    end
  endgenerate

  // Launch pulse, busy level and an always OKAY response
  assign cmd_start = r.start;
  assign cmd_busy  = !cmd_complete_flag;
  assign hresp     = fci_pkg::HRESP_OKAY;

  // Levels follow the flags, so clearing the cause drops the request
  assign cmd_complete_irq = r.cmd_ie && cmd_complete_flag;
  assign flash_error_irq  = r.err_ie && (r.ecc_single_flag || r.ecc_double_flag);

endmodule : fci_flash_cmd_if

// [fci_flash_cmd_if_sva.sv]
// Checker for the flash command interface, watching its top ports only.
// Assumes hready is the slave's own hreadyout and a single hclk domain.
module fci_flash_cmd_if_sva #(
  parameter int unsigned WORD_W = fci_pkg::WORD_W,
  parameter int unsigned DIV_W  = fci_pkg::DIV_W
) (
  input wire logic                                 hclk,
  input wire logic                                 hresetn,
  input wire logic                                 hsel,
  input wire logic [fci_pkg::DATA_W-1:0]           haddr,
  input wire logic [1:0]                           htrans,
  input wire logic                                 hwrite,
  input wire logic                                 hready,
  input wire logic [fci_pkg::DATA_W-1:0]           hrdata,
  input wire logic                                 cmd_start,
  input wire logic                                 cmd_busy,
  input wire logic [fci_pkg::WORDS*WORD_W-1:0]     cmd_words,
  input wire logic                                 ctrl_done,
  input wire logic                                 res_we,
  input wire logic                                 flash_time_tick,
  input wire logic                                 cmd_complete_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Read of either reserved word taken in its address phase
  wire rd_rsv = hsel && htrans[1] && hready && !hwrite &&
                (haddr[7:2] == fci_pkg::IDX_RSV_A || haddr[7:2] == fci_pkg::IDX_RSV_B);

  a_start_pulse: assert property (cmd_start |=> !cmd_start)
    else $error("launch pulse longer than one cycle");
  a_start_busy: assert property (cmd_start |-> cmd_busy)
    else $error("launch pulse without busy state");
  a_busy_rise: assert property ($rose(cmd_busy) |-> cmd_start)
    else $error("busy rose without launch pulse");
  a_busy_holds: assert property (cmd_busy && !ctrl_done |=> cmd_busy)
    else $error("busy dropped before controller finished");
  a_done_ready: assert property (cmd_busy && ctrl_done |=> !cmd_busy && !cmd_start)
    else $error("busy not cleared after controller finished");
  // Only result writes may touch the array while a command runs
  a_words_frozen: assert property (cmd_busy && !ctrl_done && !res_we |=> $stable(cmd_words))
    else $error("command words changed while busy");
  a_irq_ready: assert property (cmd_complete_irq |-> !cmd_busy)
    else $error("completion interrupt while busy");
  a_tick_busy: assert property (flash_time_tick |-> $past(cmd_busy))
    else $error("time base tick outside a command");
  a_rsv_zero: assert property (rd_rsv |-> ##2 hrdata == fci_pkg::RSV_READ)
    else $error("reserved word read non zero");

  c_launch: cover property (cmd_start);
  c_finish: cover property (cmd_busy && ctrl_done);
  c_rsv: cover property (rd_rsv);
endmodule : fci_flash_cmd_if_sva

bind fci_flash_cmd_if fci_flash_cmd_if_sva #(.WORD_W(WORD_W), .DIV_W(DIV_W)) fci_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .cmd_start(cmd_start),
  .cmd_busy(cmd_busy), .cmd_words(cmd_words), .ctrl_done(ctrl_done), .res_we(res_we),
  .flash_time_tick(flash_time_tick), .cmd_complete_irq(cmd_complete_irq)
);

// [fci_flash_cmd_if_tb.sv]
// Self-checking bench for the flash command interface.
// Assumes the bench is both the AHB-Lite master and the memory controller.
module fci_flash_cmd_if_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_start, cmd_busy;
  logic         res_we, ecc_we, flash_time_tick, cmd_complete_irq, flash_error_irq, rd_pend;
  logic [4:0]   evt;  // Double, single, protection, access, done
  logic [31:0]  haddr, hwdata, hrdata, r;
  logic [1:0]   htrans;
  logic [2:0]   res_sel, ecc_sel;
  logic [15:0]  res_data, ecc_data;
  logic [127:0] cmd_words;
  logic [31:0]  exp_q[$];
  logic [15:0]  wd[8];
  int           error_cnt, compares, cyc, start_cnt, tick_last, k;
  integer       seed;

  // Clock at 100 MHz
  always #5 hclk = ~hclk;

  fci_flash_cmd_if fci_flash_cmd_if_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd_start(cmd_start),
    .cmd_busy(cmd_busy), .cmd_words(cmd_words), .ctrl_done(evt[0]), .res_we(res_we),
    .res_sel(res_sel), .res_data(res_data), .access_error_set(evt[1]),
    .protection_violation_set(evt[2]), .ecc_single_set(evt[3]), .ecc_double_set(evt[4]),
    .ecc_we(ecc_we), .ecc_sel(ecc_sel), .ecc_data(ecc_data),
    .flash_time_tick(flash_time_tick), .cmd_complete_irq(cmd_complete_irq),
    .flash_error_irq(flash_error_irq)
  );

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One single transfer; holds each phase until hready is seen high
  task bus(input logic w, input logic [5:0] ix, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, ix, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task wr(input logic [5:0] ix, input logic [31:0] d);
    bus(1'b1, ix, d);
  endtask : wr

  // Notes the expected word first; the monitor compares when it arrives
  task rd(input logic [5:0] ix, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, ix, 32'h0);
  endtask : rd

  task pulse(input int b);
    @(posedge hclk);
    evt <= 5'(1 << b);
    @(posedge hclk);
    evt <= 5'h00;
    @(negedge hclk);
  endtask : pulse

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Monitor: read results, launch pulses, tick spacing and the hang limit
  always @(posedge hclk) begin
    cyc++;
    if (rd_pend && hreadyout) begin
      rd_pend = 1'b0;
      chk("hrdata", hrdata, exp_q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) begin
      rd_pend = 1'b1;
    end
    if (cmd_start === 1'b1) begin
      start_cnt++;
    end
    if (flash_time_tick === 1'b1) begin
      if (tick_last != 0) begin
        chk("tick gap", 32'(cyc - tick_last), 32'h4);
      end
      tick_last = cyc;
    end else if (cmd_busy !== 1'b1) begin
      tick_last = 0;
    end
    if (cyc > 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'hd677;
    {hclk, hresetn, hsel, hwrite, rd_pend, res_we, ecc_we} = '0;
    {evt, haddr, hwdata, htrans, res_sel, ecc_sel, res_data, ecc_data} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(fci_pkg::IDX_STATUS, 32'h80);
    rd(fci_pkg::IDX_CMD_WORD_SELECT, 32'h0);
    rd(fci_pkg::IDX_ECC_WORD_SELECT, 32'h0);
    // Index fields keep three bits; reserved and unmapped words stay zero
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      wr(fci_pkg::IDX_CMD_WORD_SELECT, r);
      rd(fci_pkg::IDX_CMD_WORD_SELECT, r & 32'h7);
      wr(fci_pkg::IDX_ECC_WORD_SELECT, ~r);
      rd(fci_pkg::IDX_ECC_WORD_SELECT, ~r & 32'h7);
      wr(fci_pkg::IDX_RSV_A, r);
      rd(fci_pkg::IDX_RSV_A, 32'h0);
      wr(fci_pkg::IDX_RSV_B, r);
      rd(fci_pkg::IDX_RSV_B, 32'h0);
      wr(6'h3f, r);
      rd(6'h3f, 32'h0);
    end
    $display("test index and reserved done");
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      wd[k] = r[15:0];
      wr(fci_pkg::IDX_CMD_WORD_SELECT, 32'(k));
      wr(fci_pkg::IDX_CCOB, r);
    end
    for (k = 0; k < 8; k++) begin
      wr(fci_pkg::IDX_CMD_WORD_SELECT, 32'(k));
      rd(fci_pkg::IDX_CCOB, {16'h0, wd[k]});
      chk("cmd word", {16'h0, cmd_words[16*k +: 16]}, {16'h0, wd[k]});
    end
    $display("test command load done");
    wr(fci_pkg::IDX_CLKDIV, 32'h3);
    rd(fci_pkg::IDX_CLKDIV, 32'h3);
    wr(fci_pkg::IDX_CONFIG, 32'h81);
    wr(fci_pkg::IDX_CMD_WORD_SELECT, 32'h0);
    wr(fci_pkg::IDX_STATUS, 32'h0);
    rd(fci_pkg::IDX_STATUS, 32'h80);
    chk("starts", 32'(start_cnt), 32'h0);
    // Launch, then try to overwrite and post a result while busy
    wr(fci_pkg::IDX_STATUS, 32'h80);
    repeat (2) @(negedge hclk);
    chk("starts", 32'(start_cnt), 32'h1);
    chk("busy", {31'h0, cmd_busy}, 32'h1);
    chk("done irq", {31'h0, cmd_complete_irq}, 32'h0);
    rd(fci_pkg::IDX_STATUS, 32'h0);
    wr(fci_pkg::IDX_CCOB, {16'h0, ~wd[0]});
    rd(fci_pkg::IDX_CCOB, {16'h0, wd[0]});
    r = $random(seed);
    wd[3] = r[15:0];
    @(posedge hclk);
    res_we   <= 1'b1;
    res_sel  <= 3'h3;
    res_data <= r[15:0];
    @(posedge hclk);
    res_we <= 1'b0;
    repeat (20) @(posedge hclk);
    pulse(0);
    chk("done irq", {31'h0, cmd_complete_irq}, 32'h1);
    rd(fci_pkg::IDX_STATUS, 32'h80);
    wr(fci_pkg::IDX_CMD_WORD_SELECT, 32'h3);
    rd(fci_pkg::IDX_CCOB, {16'h0, wd[3]});
    $display("test launch done");
    // Either error flag blocks a launch until cleared by writing one
    for (k = 1; k < 3; k++) begin
      r = (k == 1) ? 32'h20 : 32'h10;
      pulse(k);
      rd(fci_pkg::IDX_STATUS, 32'h80 | r);
      wr(fci_pkg::IDX_STATUS, 32'h80);
      repeat (2) @(negedge hclk);
      chk("starts", 32'(start_cnt), 32'h1);
      wr(fci_pkg::IDX_STATUS, r);
      rd(fci_pkg::IDX_STATUS, 32'h80);
    end
    $display("test error flags done");
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      wd[k] = r[15:0];
      @(posedge hclk);
      ecc_we   <= 1'b1;
      ecc_sel  <= 3'(k);
      ecc_data <= r[15:0];
    end
    @(posedge hclk);
    ecc_we <= 1'b0;
    for (k = 7; k >= 0; k--) begin
      wr(fci_pkg::IDX_ECC_WORD_SELECT, 32'(k));
      rd(fci_pkg::IDX_ECCR, {16'h0, wd[k]});
    end
    pulse(3);
    chk("error irq", {31'h0, flash_error_irq}, 32'h1);
    pulse(4);
    wr(fci_pkg::IDX_ERRSTAT, 32'h3);
    @(negedge hclk);
    chk("error irq", {31'h0, flash_error_irq}, 32'h0);
    $display("test ecc results done");
    repeat (3) @(posedge hclk);
    report_and_stop();
  end
endmodule : fci_flash_cmd_if_tb

// [fci_pkg.sv]
// Constants, register map and state encodings of the flash command interface.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
package fci_pkg;

  // Data path widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SEL_W  = 3;
  localparam int unsigned WORDS  = 8;
  localparam int unsigned DIV_W  = 7;
  localparam int unsigned IDX_W  = 6;

  // Word index of each register; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CLKDIV  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CMD_WORD_SELECT  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_ECC_WORD_SELECT  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CONFIG  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 6'h06;
  localparam logic [IDX_W-1:0] IDX_ERRSTAT = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CCOB    = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_ECCR    = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_RSV_A   = 6'h12;
  localparam logic [IDX_W-1:0] IDX_RSV_B   = 6'h13;

  // Address slice that selects the word index
  localparam int unsigned ADDR_IDX_LSB = 2;
  localparam int unsigned ADDR_IDX_MSB = 7;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic        HRESP_OKAY = 1'b0;

  // Field positions
  localparam int unsigned STAT_CMD_COMPLETE_FLAG_BIT   = 7;
  localparam int unsigned STAT_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int unsigned STAT_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int unsigned CFG_CCIE_BIT    = 7;
  localparam int unsigned CFG_ERRIE_BIT   = 0;
  localparam int unsigned ERR_DOUBLE_BIT  = 1;
  localparam int unsigned ERR_SINGLE_BIT  = 0;

  // Reset values
  localparam logic [DIV_W-1:0]  CLKDIV_RST = 7'h00;
  localparam logic [SEL_W-1:0]  SEL_RST    = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] RSV_READ   = 32'h0000_0000;

  typedef enum logic [0:0] {
    FCI_BUS_IDLE   = 1'b0,
    FCI_BUS_RDWAIT = 1'b1
  } fci_bus_state_t;

  typedef enum logic [0:0] {
    FCI_CMD_READY = 1'b0,
    FCI_CMD_BUSY  = 1'b1
  } fci_cmd_state_t;

endpackage : fci_pkg

// [fci_reg_if.sv]
// Register access channel between the bus front end and the register file.
// Assumes one write strobe per cycle and a combinational read return.
interface fci_reg_if;
  logic                      wr_stb;
  logic [fci_pkg::IDX_W-1:0] idx;
  logic [fci_pkg::DATA_W-1:0] wdata;
  logic [fci_pkg::DATA_W-1:0] rdata;

  modport slave (output wr_stb, output idx, output wdata, input rdata);
  modport regs  (input wr_stb, input idx, input wdata, output rdata);
endinterface : fci_reg_if

// [fci_time_base.sv]
// Flash time base: one tick every (divider + 1) oscillator cycles.
// Assumes the oscillator clock is the module clock; counts only while enabled.
module fci_time_base #(
  parameter int unsigned DIV_W = fci_pkg::DIV_W
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [DIV_W-1:0] divider,
  input  wire logic             run,
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } fci_tb_t;

  fci_tb_t r;
  fci_tb_t next_r;

  // Restarting at run keeps every command's timing aligned to its launch
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!run) begin
      next_r.cnt = '0;
    end else if (r.cnt >= divider) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = DIV_W'(r.cnt + 1'b1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{cnt: '0, tick: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule : fci_time_base
